/* design/rs485_cfg_pkg.sv */
// constants, types and line settings for the rs485 protocol port
package rs485_cfg_pkg;

	// ----------------------------------------------------------------
	// protocol, parity and state encodings
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		PROTO_NONE = 2'h0,
		PROTO_CFG_TOOL = 2'h1,
		PROTO_MSTP = 2'h2,
		PROTO_MODBUS = 2'h3
	} proto_e;

	typedef enum logic [1:0] {
		PAR_NONE = 2'h0,
		PAR_EVEN = 2'h1,
		PAR_ODD = 2'h2
	} parity_e;

	typedef enum logic [2:0] {
		LN_IDLE = 3'h0,
		LN_START = 3'h1,
		LN_DATA = 3'h3,
		LN_PAR = 3'h2,
		LN_STOP = 3'h6
	} line_state_e;

	// ----------------------------------------------------------------
	// bit rates and their select codes
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 25_000_000;
	localparam int BAUD_1200 = 1200;
	localparam int BAUD_2400 = 2400;
	localparam int BAUD_4800 = 4800;
	localparam int BAUD_9600 = 9600;
	localparam int BAUD_19200 = 19200;
	localparam int BAUD_38400 = 38400;
	localparam int BAUD_57600 = 57600;
	localparam logic [2:0] BAUD_SEL_MAX = 3'h6;
	localparam logic [2:0] BAUD_SEL_9600 = 3'h3;
	localparam logic [2:0] BAUD_SEL_19200 = 3'h4;
	localparam logic [2:0] BAUD_SEL_38400 = 3'h5;

	// ----------------------------------------------------------------
	// defaults and fixed settings
	// ----------------------------------------------------------------
	localparam logic [7:0] MODBUS_ADDR_DEF = 8'h01;
	localparam logic [2:0] MODBUS_BAUD_DEF = BAUD_SEL_9600;
	localparam logic [2:0] MSTP_BAUD_DEF = BAUD_SEL_38400;
	localparam logic [1:0] PARITY_DEF = PAR_NONE;
	localparam logic [21:0] INSTANCE_DEF = 22'h000000;
	localparam logic [21:0] INSTANCE_MAX = 22'h3FFFFF;
	localparam logic [6:0] STATION_DEF = 7'h01;
	localparam logic [6:0] MAX_MASTER_DEF = 7'h01;
	localparam logic [2:0] CFG_TOOL_BAUD = BAUD_SEL_19200;
	localparam logic [1:0] CFG_TOOL_PARITY = PAR_NONE;

	// ----------------------------------------------------------------
	// frame layout
	// ----------------------------------------------------------------
	localparam logic [7:0] MSTP_PREAMBLE_A = 8'h55;
	localparam logic [7:0] MSTP_PREAMBLE_B = 8'hFF;
	localparam logic [7:0] MSTP_BROADCAST = 8'hFF;
	localparam logic [2:0] MSTP_TYPE_IDX = 3'h2;
	localparam logic [2:0] MSTP_DEST_IDX = 3'h3;
	localparam logic [19:0] FRAME_GAP_BITS = 20'h00027;

	// clocks per bit, rounded to nearest
	function automatic logic [15:0] baud_div(input logic [2:0] sel);
		int rate;
		case (sel)
			3'h0: rate = BAUD_1200;
			3'h1: rate = BAUD_2400;
			3'h2: rate = BAUD_4800;
			3'h3: rate = BAUD_9600;
			3'h4: rate = BAUD_19200;
			3'h5: rate = BAUD_38400;
			default: rate = BAUD_57600;
		endcase
		return 16'((CLK_HZ + rate / 2) / rate);
	endfunction

endpackage

/* design/rs485_fifo.sv */
// small synchronous fifo held in flip-flops
`timescale 1ns/10ps
`default_nettype none
module rs485_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// filling side
	input wire logic i_valid,
	input wire logic [WIDTH-1:0] i_data,
	output logic o_ready,
	// draining side
	output logic o_valid,
	output logic [WIDTH-1:0] o_data,
	input wire logic i_ready
);
	localparam int AW = $clog2(DEPTH);

	// pointer wrap relies on a power-of-two depth
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
	begin : g_bad_depth
		$error("rs485_fifo depth must be a power of two");
	end

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0] wr_q;
	logic [AW:0] rd_q;
	logic push;
	logic pop;

	// extra pointer bit tells full from empty
	assign o_ready = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
	assign o_valid = wr_q != rd_q;
	assign o_data = mem_q[rd_q[AW-1:0]];
	assign push = i_valid && o_ready;
	assign pop = o_valid && i_ready;

	// pointers
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			wr_q <= '0;
			rd_q <= '0;
		end
		else
		begin
			if (push)
				wr_q <= wr_q + 1'b1;
			if (pop)
				rd_q <= rd_q + 1'b1;
		end
	end

	// storage needs no reset; only written entries are read
	always_ff @(posedge i_clk)
	begin
		if (push)
			mem_q[wr_q[AW-1:0]] <= i_data;
	end
endmodule
`default_nettype wire

/* design/rs485_port.sv */
// rs485 serial port with protocol selection, framing and address filter
`timescale 1ns/10ps
`default_nettype none
module rs485_port
	import rs485_cfg_pkg::*;
#(
	parameter int CNT_W = 16,
	parameter int TX_DEPTH = 8
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// stored configuration
	input wire logic i_cfg_valid,
	input wire logic [1:0] i_cfg_protocol,
	input wire logic [7:0] i_cfg_modbus_addr,
	input wire logic [2:0] i_cfg_baud_sel,
	input wire logic [1:0] i_cfg_parity,
	input wire logic [21:0] i_cfg_instance,
	input wire logic [6:0] i_cfg_station,
	input wire logic [6:0] i_cfg_max_master,
	// operator state
	input wire logic i_menu_open,
	// rs485 line
	input wire logic i_rxd,
	output logic o_txd,
	output logic o_de,
	// transmit stream
	input wire logic i_tx_valid,
	input wire logic [7:0] i_tx_data,
	input wire logic i_tx_last,
	output logic o_tx_ready,
	// receive stream
	output logic o_rx_valid,
	output logic [7:0] o_rx_data,
	output logic [7:0] o_rx_frame_type,
	output logic o_rx_frame_done,
	output logic o_rx_frame_good,
	// status
	output logic [1:0] o_protocol,
	output logic [21:0] o_instance,
	output logic [6:0] o_station,
	output logic [6:0] o_next_station,
	output logic [CNT_W-1:0] o_tx_count,
	output logic [CNT_W-1:0] o_rx_count,
	output logic o_suspended
);
	if (CNT_W < 1 || TX_DEPTH < 2)
	begin : g_bad_param
		$error("rs485_port counter width or fifo depth out of range");
	end

	// ----------------------------------------------------------------
	// protocol capture and effective line settings
	// ----------------------------------------------------------------
	logic loaded_q;
	proto_e proto_q;
	logic [15:0] div_q;
	logic [19:0] gap_q;
	logic [1:0] par_q;
	logic [7:0] addr_q;
	logic [2:0] baud_d;
	logic [1:0] par_d;
	line_state_e tx_st_q;
	line_state_e rx_st_q;
	logic suspend;

	assign suspend = i_menu_open;

	// protocol is caught once after reset and then held
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			loaded_q <= 1'b0;
			proto_q <= PROTO_NONE;
		end
		else if (!loaded_q)
		begin
			loaded_q <= 1'b1;
			proto_q <= proto_e'(i_cfg_protocol);
		end
	end

	// fixed settings for the config tool, defaults for bad or empty store
	always_comb
	begin
		baud_d = i_cfg_baud_sel;
		par_d = i_cfg_parity;
		if (!i_cfg_valid || i_cfg_baud_sel > BAUD_SEL_MAX)
			baud_d = (proto_q == PROTO_MODBUS) ? MODBUS_BAUD_DEF : MSTP_BAUD_DEF;
		if (!i_cfg_valid || i_cfg_parity > PAR_ODD)
			par_d = PARITY_DEF;
		if (proto_q == PROTO_CFG_TOOL)
		begin
			baud_d = CFG_TOOL_BAUD;
			par_d = CFG_TOOL_PARITY;
		end
	end

	// settings change only between characters to avoid a torn bit
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			div_q <= baud_div(MODBUS_BAUD_DEF);
			gap_q <= 20'(baud_div(MODBUS_BAUD_DEF) * FRAME_GAP_BITS);
			par_q <= PARITY_DEF;
			addr_q <= MODBUS_ADDR_DEF;
			o_instance <= INSTANCE_DEF;
			o_station <= STATION_DEF;
			o_next_station <= 7'h00;
		end
		else if (tx_st_q == LN_IDLE && rx_st_q == LN_IDLE)
		begin
			div_q <= baud_div(baud_d);
			gap_q <= 20'(baud_div(baud_d) * FRAME_GAP_BITS);
			par_q <= par_d;
			addr_q <= (i_cfg_valid && i_cfg_modbus_addr != 8'h00) ?
				i_cfg_modbus_addr : MODBUS_ADDR_DEF;
			o_instance <= (i_cfg_valid && i_cfg_instance <= INSTANCE_MAX) ?
				i_cfg_instance : INSTANCE_DEF;
			o_station <= i_cfg_valid ? i_cfg_station : STATION_DEF;
			// token goes to the next station, wrapping past max master
			if (!i_cfg_valid)
				o_next_station <= (STATION_DEF >= MAX_MASTER_DEF) ?
					7'h00 : STATION_DEF + 7'h01;
			else
				o_next_station <= (i_cfg_station >= i_cfg_max_master) ?
					7'h00 : i_cfg_station + 7'h01;
		end
	end

	assign o_protocol = proto_q;
	assign o_suspended = suspend;

	// ----------------------------------------------------------------
	// transmit path: fifo then character framer
	// ----------------------------------------------------------------
	logic f_valid;
	logic [8:0] f_data;
	logic tx_pop;
	logic [15:0] tx_cnt_q;
	logic [2:0] tx_bit_q;
	logic [7:0] tx_sh_q;
	logic tx_last_q;
	logic tx_par_q;
	logic tx_tick;

	rs485_fifo #(
		.WIDTH(9),
		.DEPTH(TX_DEPTH)
	) u_tx_fifo (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_valid(i_tx_valid),
		.i_data({i_tx_last, i_tx_data}),
		.o_ready(o_tx_ready),
		.o_valid(f_valid),
		.o_data(f_data),
		.i_ready(tx_pop)
	);

	// no new character while menus are open or before a protocol is live
	assign tx_pop = (tx_st_q == LN_IDLE) && f_valid && !suspend &&
		loaded_q && (proto_q != PROTO_NONE);
	assign tx_tick = tx_cnt_q == 16'h0000;

	// one character: start, eight data bits lsb first, parity unless PAR_NONE, stop
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			tx_st_q <= LN_IDLE;
			tx_cnt_q <= 16'h0000;
			tx_bit_q <= 3'h0;
			tx_sh_q <= 8'h00;
			tx_last_q <= 1'b0;
			tx_par_q <= 1'b0;
			o_txd <= 1'b1;
			o_de <= 1'b0;
			o_tx_count <= '0;
		end
		else
		begin
			tx_cnt_q <= tx_tick ? div_q - 16'h0001 : tx_cnt_q - 16'h0001;
			case (tx_st_q)
				LN_IDLE:
					if (tx_pop)
					begin
						tx_st_q <= LN_START;
						tx_cnt_q <= div_q - 16'h0001;
						tx_sh_q <= f_data[7:0];
						tx_last_q <= f_data[8];
						tx_par_q <= (par_q == PAR_ODD) ? ~^f_data[7:0] : ^f_data[7:0];
						o_txd <= 1'b0;
						o_de <= 1'b1;
					end
				LN_START:
					if (tx_tick)
					begin
						tx_st_q <= LN_DATA;
						tx_bit_q <= 3'h0;
						o_txd <= tx_sh_q[0];
					end
				LN_DATA:
					if (tx_tick)
					begin
						if (tx_bit_q == 3'h7)
						begin
							tx_st_q <= (par_q == PAR_NONE) ? LN_STOP : LN_PAR;
							o_txd <= (par_q == PAR_NONE) ? 1'b1 : tx_par_q;
						end
						else
						begin
							tx_bit_q <= tx_bit_q + 3'h1;
							tx_sh_q <= {1'b0, tx_sh_q[7:1]};
							o_txd <= tx_sh_q[1];
						end
					end
				LN_PAR:
					if (tx_tick)
					begin
						tx_st_q <= LN_STOP;
						o_txd <= 1'b1;
					end
				LN_STOP:
					if (tx_tick)
					begin
						tx_st_q <= LN_IDLE;
						// bus is let go at the end of the last stop bit
						if (tx_last_q)
						begin
							o_de <= 1'b0;
							o_tx_count <= o_tx_count + 1'b1;
						end
					end
				default:
					tx_st_q <= LN_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// receive path: synchroniser and character deframer
	// ----------------------------------------------------------------
	logic rxd_m_q;
	logic rxd_q;
	logic [15:0] rx_cnt_q;
	logic [2:0] rx_bit_q;
	logic [7:0] rx_sh_q;
	logic rx_err_q;
	logic rx_stb_q;
	logic rx_tick;

	// two flops before anything looks at the line
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			rxd_m_q <= 1'b1;
			rxd_q <= 1'b1;
		end
		else
		begin
			rxd_m_q <= i_rxd;
			rxd_q <= rxd_m_q;
		end
	end

	assign rx_tick = rx_cnt_q == 16'h0000;

	// sampling at mid-bit; a start glitch shorter than half a bit is dropped
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			rx_st_q <= LN_IDLE;
			rx_cnt_q <= 16'h0000;
			rx_bit_q <= 3'h0;
			rx_sh_q <= 8'h00;
			rx_err_q <= 1'b0;
			rx_stb_q <= 1'b0;
		end
		else
		begin
			rx_stb_q <= 1'b0;
			rx_cnt_q <= rx_tick ? div_q - 16'h0001 : rx_cnt_q - 16'h0001;
			case (rx_st_q)
				LN_IDLE:
					if (!rxd_q)
					begin
						rx_st_q <= LN_START;
						rx_cnt_q <= {1'b0, div_q[15:1]};
						rx_err_q <= 1'b0;
					end
				LN_START:
					if (rx_tick)
					begin
						rx_st_q <= rxd_q ? LN_IDLE : LN_DATA;
						rx_bit_q <= 3'h0;
					end
				LN_DATA:
					if (rx_tick)
					begin
						rx_sh_q <= {rxd_q, rx_sh_q[7:1]};
						rx_bit_q <= rx_bit_q + 3'h1;
						if (rx_bit_q == 3'h7)
							rx_st_q <= (par_q == PAR_NONE) ? LN_STOP : LN_PAR;
					end
				LN_PAR:
					if (rx_tick)
					begin
						rx_st_q <= LN_STOP;
						rx_err_q <= rxd_q != ((par_q == PAR_ODD) ? ~^rx_sh_q : ^rx_sh_q);
					end
				LN_STOP:
					if (rx_tick)
					begin
						rx_st_q <= LN_IDLE;
						rx_stb_q <= 1'b1;
						if (!rxd_q)
							rx_err_q <= 1'b1;
					end
				default:
					rx_st_q <= LN_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// frame tracking and address filter
	// ----------------------------------------------------------------
	logic [19:0] idle_q;
	logic in_frame_q;
	logic [2:0] idx_q;
	logic [2:0] idx;
	logic acc_q;
	logic rej_q;
	logic bad_q;

	// an idle gap of several characters closes a frame
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			idle_q <= 20'h00000;
		else if (rx_st_q != LN_IDLE || !rxd_q)
			idle_q <= 20'h00000;
		else if (idle_q != gap_q)
			idle_q <= idle_q + 20'h00001;
	end

	assign idx = in_frame_q ? idx_q : 3'h0;

	// accept/reject is decided on the address byte of modbus and mstp; the config tool takes every byte
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			in_frame_q <= 1'b0;
			idx_q <= 3'h0;
			acc_q <= 1'b0;
			rej_q <= 1'b0;
			bad_q <= 1'b0;
			o_rx_valid <= 1'b0;
			o_rx_data <= 8'h00;
			o_rx_frame_type <= 8'h00;
			o_rx_frame_done <= 1'b0;
			o_rx_frame_good <= 1'b0;
			o_rx_count <= '0;
		end
		else
		begin
			o_rx_valid <= 1'b0;
			o_rx_frame_done <= 1'b0;
			if (suspend || !loaded_q || proto_q == PROTO_NONE)
			begin
				in_frame_q <= 1'b0;
				acc_q <= 1'b0;
			end
			else if (rx_stb_q)
			begin
				in_frame_q <= 1'b1;
				idx_q <= (idx == 3'h7) ? idx : idx + 3'h1;
				if (!in_frame_q)
				begin
					acc_q <= 1'b0;
					rej_q <= 1'b0;
					bad_q <= rx_err_q;
				end
				else if (rx_err_q)
					bad_q <= 1'b1;
				o_rx_data <= rx_sh_q;
				case (proto_q)
					PROTO_CFG_TOOL:
					begin
						acc_q <= 1'b1;
						o_rx_valid <= 1'b1;
					end
					PROTO_MODBUS:
						if (idx == 3'h0)
							acc_q <= rx_sh_q == addr_q;
						else
							o_rx_valid <= acc_q;
					PROTO_MSTP:
						if (idx == 3'h0)
							rej_q <= rx_sh_q != MSTP_PREAMBLE_A;
						else if (idx == 3'h1)
							rej_q <= rej_q || rx_sh_q != MSTP_PREAMBLE_B;
						else if (idx == MSTP_TYPE_IDX)
							o_rx_frame_type <= rx_sh_q;
						else if (idx == MSTP_DEST_IDX)
							acc_q <= !rej_q && (rx_sh_q == {1'b0, o_station} ||
								rx_sh_q == MSTP_BROADCAST);
						else
							o_rx_valid <= acc_q;
					default:
						acc_q <= 1'b0;
				endcase
			end
			else if (in_frame_q && idle_q == gap_q)
			begin
				in_frame_q <= 1'b0;
				o_rx_frame_done <= acc_q;
				o_rx_frame_good <= acc_q && !bad_q;
				if (acc_q && !bad_q)
					o_rx_count <= o_rx_count + 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

/* testbench/rs485_port_properties.sv */
// concurrent checks on the rs485 port pins
`timescale 1ns/10ps
`default_nettype none
module rs485_port_checker
	import rs485_cfg_pkg::*;
#(
	parameter int CNT_W = 16
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// settings and operator state
	input wire logic i_cfg_valid,
	input wire logic [6:0] i_cfg_max_master,
	input wire logic i_menu_open,
	// line and stream outputs
	input wire logic o_txd,
	input wire logic o_de,
	input wire logic o_rx_valid,
	// status outputs
	input wire logic [1:0] o_protocol,
	input wire logic [6:0] o_station,
	input wire logic [6:0] o_next_station,
	input wire logic [CNT_W-1:0] o_tx_count,
	input wire logic [CNT_W-1:0] o_rx_count,
	input wire logic o_suspended
);
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);

	chk_reset_idle: assert property (
		$fell(i_rst) |-> !o_de && o_txd && o_tx_count == '0)
		else $error("line not released after reset");
	chk_idle_high: assert property (!o_de |-> o_txd)
		else $error("line not high while released");
	chk_start_bit: assert property ($rose(o_de) |-> !o_txd)
		else $error("driver enabled without start bit");
	chk_proto_held: assert property (
		o_protocol != PROTO_NONE |=> o_protocol == $past(o_protocol))
		else $error("protocol changed without reset");
	chk_suspend_flag: assert property (o_suspended == i_menu_open)
		else $error("suspend flag wrong");
	chk_menu_blocks: assert property (
		(i_menu_open && !o_de) [*3] |=> !o_de)
		else $error("frame started while menus open");
	chk_tx_count_step: assert property (
		o_tx_count != $past(o_tx_count) |->
		o_tx_count == CNT_W'($past(o_tx_count) + 1) && $fell(o_de))
		else $error("tx count step wrong");
	chk_rx_count_step: assert property (
		o_rx_count != $past(o_rx_count) |->
		o_rx_count == CNT_W'($past(o_rx_count) + 1))
		else $error("rx count step wrong");
	chk_rx_pulse: assert property (o_rx_valid |=> !o_rx_valid)
		else $error("byte strobe longer than one cycle");
	// only judged once settings and result have settled for a cycle;
	// settings reload whenever both line paths are idle, also between the
	// characters of a frame, so the result can change while the bus is still driven
	chk_next_station: assert property (
		o_protocol == PROTO_MSTP && i_cfg_valid && !o_de && !$past(o_de)
		&& $stable(i_cfg_max_master) && $stable(o_next_station) |->
		o_next_station ==
		((o_station >= i_cfg_max_master) ? 7'h00 : o_station + 7'h01))
		else $error("next station wrong");

	cov_tx_end: cover property ($fell(o_de));
	cov_rx_count: cover property (o_rx_count != $past(o_rx_count));
	cov_mstp: cover property (o_protocol == PROTO_MSTP);
endmodule
bind rs485_port rs485_port_checker #(.CNT_W(CNT_W)) i_chk (
	.i_clk(i_clk),
	.i_rst(i_rst),
	.i_cfg_valid(i_cfg_valid),
	.i_cfg_max_master(i_cfg_max_master),
	.i_menu_open(i_menu_open),
	.o_txd(o_txd),
	.o_de(o_de),
	.o_rx_valid(o_rx_valid),
	.o_protocol(o_protocol),
	.o_station(o_station),
	.o_next_station(o_next_station),
	.o_tx_count(o_tx_count),
	.o_rx_count(o_rx_count),
	.o_suspended(o_suspended)
);
`default_nettype wire

/* testbench/bms_master.sv */
// behavioural bus master on the rs485 line
`timescale 1ns/10ps
`default_nettype none
module bms_master
	import rs485_cfg_pkg::*;
(
	// clock and line settings
	input wire logic i_clk,
	input wire logic [15:0] i_div,
	input wire logic [1:0] i_par,
	// rs485 line
	input wire logic i_txd,
	output logic o_line
);
	// biased bus idles high between characters
	initial o_line = 1'b1;

	// parity bit of a character
	function automatic logic par_bit(input logic [7:0] b);
		return (i_par == PAR_ODD) ? ~^b : ^b;
	endfunction

	// one character, lsb first, stop bit left standing
	task automatic send_byte(input logic [7:0] b);
		logic [10:0] f;
		int n;
		f = {2'b11, b, 1'b0};
		n = 10;
		if (i_par != PAR_NONE)
		begin
			f[9] = par_bit(b);
			n = 11;
		end
		for (int i = 0; i < n; i++)
		begin
			@(posedge i_clk);
			o_line <= f[i];
			repeat (i_div - 1) @(posedge i_clk);
		end
	endtask

	// sample each bit at its middle; returns inside the stop bit
	task automatic recv_byte(output logic [7:0] b, output logic p,
		output logic s);
		while (i_txd !== 1'b0) @(posedge i_clk);
		repeat (i_div / 2) @(posedge i_clk);
		for (int i = 0; i < 8; i++)
		begin
			repeat (i_div) @(posedge i_clk);
			b[i] = i_txd;
		end
		p = 1'b1;
		if (i_par != PAR_NONE)
		begin
			repeat (i_div) @(posedge i_clk);
			p = i_txd;
		end
		repeat (i_div) @(posedge i_clk);
		s = i_txd;
	endtask
endmodule
`default_nettype wire

/* testbench/tb.sv */
// self-checking bench for the rs485 protocol port
`timescale 1ns/10ps
`default_nettype none
module tb;
	import rs485_cfg_pkg::*;
	// ----------------------------------------------------------------
	// stimulus and observed signals
	// ----------------------------------------------------------------
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cfg_valid = 1'b1;
	logic [1:0] cfg_proto = PROTO_MODBUS;
	logic [7:0] cfg_addr = 8'h05;
	logic [2:0] cfg_baud = BAUD_SEL_MAX;
	logic [1:0] cfg_par = PAR_NONE;
	logic [21:0] cfg_inst = 22'h3FFFFF;
	logic [6:0] cfg_stn = 7'h03;
	logic [6:0] cfg_maxm = 7'h03;
	logic menu = 1'b0;
	logic tx_valid = 1'b0;
	logic [7:0] tx_data = 8'h00;
	logic tx_last = 1'b0;
	logic [15:0] bdiv = 16'h01B2;
	logic [1:0] bpar = PAR_NONE;
	logic rxd, txd, de, tx_ready, rx_valid, rx_done, rx_good, susp;
	logic [7:0] rx_data;
	logic [1:0] proto;
	logic [21:0] inst;
	logic [6:0] stn, nxt;
	logic [15:0] tx_cnt, rx_cnt;
	logic [7:0] rx_last = 8'h00;
	int rx_seen = 0;
	int num_errors = 0;
	int n_tests = 0;

	always #20 clk = ~clk;

	rs485_port #(.CNT_W(16), .TX_DEPTH(8)) i_dut (
		.i_clk(clk), .i_rst(rst), .i_cfg_valid(cfg_valid),
		.i_cfg_protocol(cfg_proto), .i_cfg_modbus_addr(cfg_addr),
		.i_cfg_baud_sel(cfg_baud), .i_cfg_parity(cfg_par),
		.i_cfg_instance(cfg_inst), .i_cfg_station(cfg_stn),
		.i_cfg_max_master(cfg_maxm), .i_menu_open(menu), .i_rxd(rxd),
		.o_txd(txd), .o_de(de), .i_tx_valid(tx_valid), .i_tx_data(tx_data),
		.i_tx_last(tx_last), .o_tx_ready(tx_ready), .o_rx_valid(rx_valid),
		.o_rx_data(rx_data), .o_rx_frame_type(), .o_rx_frame_done(rx_done),
		.o_rx_frame_good(rx_good), .o_protocol(proto), .o_instance(inst),
		.o_station(stn), .o_next_station(nxt), .o_tx_count(tx_cnt),
		.o_rx_count(rx_cnt), .o_suspended(susp));

	bms_master bms (.i_clk(clk), .i_div(bdiv), .i_par(bpar), .i_txd(txd),
		.o_line(rxd));

	// keep the last delivered byte and how many arrived
	always @(posedge clk)
		if (rx_valid === 1'b1)
		begin
			rx_seen <= rx_seen + 1;
			rx_last <= rx_data;
		end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		n_tests++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[FAIL] %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	task automatic do_reset();
		rst <= 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
	endtask

	// hold the word until the fifo takes it; the caller drops valid, so
	// back-to-back words never lower and raise it in one time step
	task automatic put(input logic [7:0] d, input logic l);
		tx_valid <= 1'b1;
		tx_data <= d;
		tx_last <= l;
		do @(posedge clk); while (tx_ready !== 1'b1);
	endtask

	task automatic send_get(input logic [7:0] d, output logic p);
		logic [7:0] b;
		logic s;
		put(d, 1'b1);
		tx_valid <= 1'b0;
		bms.recv_byte(b, p, s);
		check("tx byte", d, b);
		check("tx stop", 1, s);
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	// a clean run takes about 85000 cycles; the limit leaves headroom
	initial
	begin
		repeat (100000) @(posedge clk);
		num_errors++;
		close_out();
	end

	initial
	begin
		logic [7:0] b;
		logic p, s;
		do_reset();
		check("de after reset", 0, de);
		check("protocol", PROTO_MODBUS, proto);
		cfg_proto <= PROTO_MSTP;
		repeat (3) @(posedge clk);
		check("protocol held", PROTO_MODBUS, proto);
		// address byte is stripped, payload delivered
		bms.send_byte(8'h05);
		bms.send_byte(8'hA5);
		while (rx_done !== 1'b1) @(posedge clk);
		check("frame good", 1, rx_good);
		check("rx bytes", 1, rx_seen);
		check("rx data", 8'hA5, rx_last);
		check("rx count", 1, rx_cnt);
		// a frame for another slave must leave no trace
		bms.send_byte(8'h06);
		bms.send_byte(8'h3C);
		repeat (17500) @(posedge clk);
		check("foreign bytes", 1, rx_seen);
		check("foreign count", 1, rx_cnt);
		// menus hold the queue back until it refuses
		menu <= 1'b1;
		@(posedge clk);
		check("suspended", 1, susp);
		for (int i = 0; i < 8; i++)
			put(8'(8'h30 + i), 1'(i == 7));
		tx_valid <= 1'b0;
		@(posedge clk);
		check("fifo full", 0, tx_ready);
		check("de in menus", 0, de);
		menu <= 1'b0;
		// two characters are enough; a reset then cuts the frame short
		for (int i = 0; i < 2; i++)
		begin
			bms.recv_byte(b, p, s);
			check("queued byte", 8'(8'h30 + i), b);
			check("de held", 1, de);
		end
		// node settings and parity modes
		cfg_par <= PAR_EVEN;
		bpar <= PAR_EVEN;
		do_reset();
		check("de after cut", 0, de);
		check("tx count cleared", 0, tx_cnt);
		check("protocol", PROTO_MSTP, proto);
		check("instance", 22'h3FFFFF, inst);
		check("station", 3, stn);
		check("next station", 0, nxt);
		send_get(8'h07, p);
		check("even parity", 1, p);
		cfg_par <= PAR_ODD;
		bpar <= PAR_ODD;
		cfg_maxm <= 7'h7F;
		cfg_stn <= 7'h05;
		cfg_inst <= 22'h2AAAA5;
		cfg_proto <= PROTO_MODBUS;
		repeat (bdiv) @(posedge clk);
		check("next station", 6, nxt);
		check("new station", 5, stn);
		check("new instance", 22'h2AAAA5, inst);
		check("protocol held", PROTO_MSTP, proto);
		send_get(8'h07, p);
		check("odd parity", 0, p);
		repeat (bdiv) @(posedge clk);
		check("de released", 0, de);
		check("tx count", 2, tx_cnt);
		// fixed line: baud and parity settings ignored
		cfg_proto <= PROTO_CFG_TOOL;
		cfg_par <= PAR_EVEN;
		cfg_baud <= BAUD_SEL_9600;
		bpar <= PAR_NONE;
		bdiv <= 16'h0516;
		do_reset();
		check("protocol", PROTO_CFG_TOOL, proto);
		send_get(8'h5A, p);
		// unset storage falls back to defaults
		cfg_valid <= 1'b0;
		do_reset();
		check("default station", 1, stn);
		check("default instance", 0, inst);
		check("default next", 0, nxt);
		close_out();
	end
endmodule
`default_nettype wire
